// [inc/eeprom_defs.vh]
// Constants shared by the two-wire nonvolatile memory write slave.
//
// Contract
// - The data line changes only while the clock is low; high-clock changes are conditions.
// - Data falling while the clock is high is a start, beginning a new transfer.
// - Data rising while the clock is high is a stop, returning to standby.
// - Words are eight bits; each received word is acknowledged low on the ninth clock.
// - Standby at power-up and after a stop once internal work is done.
// - Start, nine clocks, start, stop leaves the slave idle and ready.
// - The upper four address-word bits must equal the device-type pattern.
// - The next three address-word bits must match the chip-select address pins.
// - The last address-word bit selects direction: one reads, zero writes.
// - A matching address is acknowledged; a mismatch gets no acknowledge and standby.
// - While write inhibit is high nothing in the memory is programmed; here it is read at the stop only, so a running program cycle completes.
// - A byte write is device address, two address bytes, one data byte, stop.
// - The stop ending a write starts a timed program cycle that ignores the bus.
// - The program cycle lasts from the stop and ends within five milliseconds; here it ends no earlier than five milliseconds, later while the memory stalls.
// - A page write carries up to 64 data bytes before the stop.
// - Only the low six address bits advance per byte; the page wraps.
// - During a program cycle the address is not acknowledged; afterwards it is.
// - Bits are sampled on the clock rise and acknowledges driven after the fall.
// - The memory is 256 pages of 64 bytes with a 14-bit word address.
`ifndef EEPROM_DEFS_VH
`define EEPROM_DEFS_VH

`define DEV_TYPE_PATTERN 4'hA
`define BITS_PER_WORD 4'h8
`define WORD_ADDR_BITS 14
`define PAGE_OFFSET_BITS 6
`define PAGE_BYTES 64
`define HI_ADDR_KEEP_BITS 6
`define WR_FIFO_DEPTH 8
`define CLK_PERIOD_NS 50
`define INTERNAL_PROGRAM_TIME_MS 5
`define PROG_CYCLES_DEF ((`INTERNAL_PROGRAM_TIME_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// [logic/sync_two_flop.v]
// Two-flop synchroniser for levels entering the clock domain.
`timescale 1ns/1ps
`default_nettype none

module sync_two_flop #(
    parameter WIDTH = 1
) (
    // Clock and reset.
    input wire clk,
    input wire rst_n,
    // Data.
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] dout
);

    reg [WIDTH-1:0] stage;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage <= {WIDTH{1'b0}};
            dout <= {WIDTH{1'b0}};
        end else begin
            stage <= din;
            dout <= stage;
        end
    end

endmodule

`default_nettype wire

// [logic/write_fifo.v]
// Synchronous FIFO with a registered output stage.
`timescale 1ns/1ps
`default_nettype none

module write_fifo #(
    parameter WIDTH = 22,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // Clock and reset.
    input wire clk,
    input wire rst_n,
    // Filling side.
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Draining side.
    output reg out_valid,
    input wire out_ready,
    output reg [WIDTH-1:0] out_data,
    // Status.
    output wire empty
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;

    wire push = in_valid && in_ready;
    wire pop = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);

    assign in_ready = (count != DEPTH[AW:0]);
    assign empty = (count == {(AW+1){1'b0}}) && !out_valid;

    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
                out_data <= mem[rd_ptr];
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// [logic/eeprom_write_slave.v]
// Two-wire serial slave front end with page buffer and timed program cycle.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_defs.vh"

module eeprom_write_slave #(
    parameter [23:0] PROG_CYCLES = `PROG_CYCLES_DEF,
    parameter FIFO_DEPTH = `WR_FIFO_DEPTH
) (
    // Clock and reset.
    input wire MCLK,
    input wire RESETN,
    // Two-wire bus.
    input wire SCL,
    input wire SDA_IN,
    output reg SDA_OUT,
    output reg SDA_OE,
    // Straps.
    input wire [2:0] CHIP_SELECT_ADDRESS_PINS,
    input wire WRITE_INHIBIT,
    // Status.
    output reg STANDBY,
    output reg PROGRAM_BUSY,
    // Memory write port.
    output wire MEM_WR_VALID,
    input wire MEM_WR_READY,
    output wire [`WORD_ADDR_BITS-1:0] MEM_WR_ADDR,
    output wire [7:0] MEM_WR_DATA
);

    // =====================================================================
    // States
    // =====================================================================
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_DEV = 3'h1;
    localparam [2:0] ST_ADDR_HI = 3'h2;
    localparam [2:0] ST_ADDR_LO = 3'h3;
    localparam [2:0] ST_DATA = 3'h4;
    localparam [2:0] ST_IGNORE = 3'h5;
    localparam [2:0] ST_PROG = 3'h6;

    localparam [23:0] PROG_LAST = PROG_CYCLES - 24'h000001;
    localparam FW = `WORD_ADDR_BITS + 8;

    // =====================================================================
    // Overview
    // =====================================================================
    // The slave has no clock of its own on the bus side: both bus lines are
    // sampled by the system clock, and their edges are found by comparing
    // the synchronised level with the level one cycle earlier.
    // A transfer walks through the device word, the two address bytes and
    // any number of data bytes.
    // Data bytes are kept in a page buffer, each marked valid at its offset,
    // so that a page write longer than one page simply overwrites the
    // oldest bytes and only the last byte per offset is committed.
    // Nothing reaches the memory port before the stop that ends the write;
    // a start or an inhibited stop throws the buffered page away.
    // While the program cycle runs, the bus is not looked at at all, which
    // is also why polling during the cycle gets no acknowledge.
    // The program cycle ends when the timer has run its full length and the
    // write queue toward the memory has drained; a slow memory therefore
    // stretches the cycle instead of losing bytes.

    // =====================================================================
    // Reset release and input synchronisers
    // =====================================================================
    wire rst_n;
    wire scl;
    wire sda;
    wire scl_low;
    wire sda_low;
    wire [2:0] cs_pins;
    wire inhibit;

    // The bus lines are synchronised inverted, so that the synchroniser's
    // reset value of zero stands for the idle high level of the bus.
    // Without this, the first cycles after reset would show a false clock
    // edge to the edge detector below.
    assign scl = !scl_low;
    assign sda = !sda_low;

    sync_two_flop #(.WIDTH(1)) u_rst_sync (
        .clk(MCLK),
        .rst_n(RESETN),
        .din(1'b1),
        .dout(rst_n)
    );

    sync_two_flop #(.WIDTH(6)) u_pin_sync (
        .clk(MCLK),
        .rst_n(rst_n),
        .din({!SCL, !SDA_IN, CHIP_SELECT_ADDRESS_PINS, WRITE_INHIBIT}),
        .dout({scl_low, sda_low, cs_pins, inhibit})
    );

    // =====================================================================
    // Bus condition detection
    // =====================================================================
    reg scl_d;
    reg sda_d;

    always @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl;
            sda_d <= sda;
        end
    end

    // A bit is taken three system clocks after the bus clock rises at the
    // pin: two synchroniser stages and the edge register. The bus clock
    // must therefore stay high and low for at least three system clocks.
    wire scl_rise = scl && !scl_d;
    wire scl_fall = !scl && scl_d;
    // Data moving while the clock stays high is a condition, never a bit.
    wire start_cond = scl && scl_d && sda_d && !sda;
    wire stop_cond = scl && scl_d && !sda_d && sda;

    // =====================================================================
    // Protocol state
    // =====================================================================
    reg [2:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] shift;
    reg in_ack;
    reg [`WORD_ADDR_BITS-1:0] word_addr;
    reg [`PAGE_BYTES-1:0] page_valid;
    reg [23:0] timer;
    reg [6:0] drain_idx;
    reg [7:0] page_buf [0:`PAGE_BYTES-1];

    wire active = (state != ST_IDLE) && (state != ST_PROG);
    wire byte_done = active && !start_cond && !stop_cond && scl_fall && !in_ack && (bit_cnt == `BITS_PER_WORD);
    wire dev_match = (shift[7:4] == `DEV_TYPE_PATTERN) && (shift[3:1] == cs_pins);
    wire [`PAGE_OFFSET_BITS-1:0] offset = word_addr[`PAGE_OFFSET_BITS-1:0];
    wire [`PAGE_OFFSET_BITS-1:0] next_offset = offset + 1'b1;

    // Page drain toward the memory write port.
    wire fifo_in_ready;
    wire fifo_empty;
    wire drain_done = drain_idx[6];
    wire [`PAGE_OFFSET_BITS-1:0] drain_off = drain_idx[5:0];
    wire drain_hit = page_valid[drain_off];
    wire fifo_in_valid = (state == ST_PROG) && !drain_done && drain_hit;
    wire drain_step = (state == ST_PROG) && !drain_done && (!drain_hit || fifo_in_ready);
    wire [FW-1:0] fifo_in_data = {word_addr[`WORD_ADDR_BITS-1:`PAGE_OFFSET_BITS], drain_off, page_buf[drain_off]};
    wire prog_end = (timer == PROG_LAST) && drain_done && fifo_empty;

    // The drain walks all 64 offsets in order and pushes only those that
    // were written, one per cycle while the queue has room. The page bits
    // of every pushed word come from the address that the write loaded.

    // The page buffer holds the bytes until the stop commits them.
    always @(posedge MCLK) begin
        if (byte_done && state == ST_DATA) begin
            page_buf[offset] <= shift;
        end
    end

    always @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            in_ack <= 1'b0;
            SDA_OE <= 1'b0;
            word_addr <= {`WORD_ADDR_BITS{1'b0}};
            page_valid <= {`PAGE_BYTES{1'b0}};
            timer <= 24'h000000;
            drain_idx <= 7'h00;
        end else if (state == ST_PROG) begin
            // The bus is not watched at all while programming.
            SDA_OE <= 1'b0;
            if (timer != PROG_LAST) begin
                timer <= timer + 24'h000001;
            end
            if (drain_step) begin
                drain_idx <= drain_idx + 7'h01;
            end
            if (prog_end) begin
                page_valid <= {`PAGE_BYTES{1'b0}};
                state <= ST_IDLE;
            end
        end else if (start_cond) begin
            // A start anywhere aborts the transfer and expects an address.
            state <= ST_DEV;
            bit_cnt <= 4'h0;
            in_ack <= 1'b0;
            SDA_OE <= 1'b0;
        end else if (stop_cond) begin
            bit_cnt <= 4'h0;
            in_ack <= 1'b0;
            SDA_OE <= 1'b0;
            if (state == ST_DATA && page_valid != {`PAGE_BYTES{1'b0}} && !inhibit) begin
                state <= ST_PROG;
                timer <= 24'h000000;
                drain_idx <= 7'h00;
            end else begin
                page_valid <= {`PAGE_BYTES{1'b0}};
                state <= ST_IDLE;
            end
        end else if (active) begin
            if (scl_rise && !in_ack) begin
                shift <= {shift[6:0], sda};
                bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && in_ack) begin
                // The ninth clock is over; let go of the data line.
                in_ack <= 1'b0;
                SDA_OE <= 1'b0;
            end else if (byte_done) begin
                bit_cnt <= 4'h0;
                in_ack <= 1'b1;
                case (state)
                    ST_DEV: begin
                        if (dev_match) begin
                            SDA_OE <= 1'b1;
                            // Reading is served elsewhere; only writes proceed here.
                            state <= shift[0] ? ST_IGNORE : ST_ADDR_HI;
                        end else begin
                            SDA_OE <= 1'b0;
                            state <= ST_IDLE;
                        end
                    end
                    ST_ADDR_HI: begin
                        SDA_OE <= 1'b1;
                        word_addr[`WORD_ADDR_BITS-1:8] <= shift[`HI_ADDR_KEEP_BITS-1:0];
                        state <= ST_ADDR_LO;
                    end
                    ST_ADDR_LO: begin
                        SDA_OE <= 1'b1;
                        word_addr[7:0] <= shift;
                        page_valid <= {`PAGE_BYTES{1'b0}};
                        state <= ST_DATA;
                    end
                    ST_DATA: begin
                        SDA_OE <= 1'b1;
                        page_valid[offset] <= 1'b1;
                        // Only the in-page offset advances, so the page wraps.
                        word_addr[`PAGE_OFFSET_BITS-1:0] <= next_offset;
                    end
                    ST_IGNORE: begin
                        SDA_OE <= 1'b0;
                    end
                    default: begin
                        SDA_OE <= 1'b0;
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // =====================================================================
    // Status outputs
    // =====================================================================
    // The data output only ever pulls low; the enable carries the
    // acknowledge. Standby and busy follow the state one cycle later.
    always @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            SDA_OUT <= 1'b0;
            STANDBY <= 1'b1;
            PROGRAM_BUSY <= 1'b0;
        end else begin
            SDA_OUT <= 1'b0;
            STANDBY <= (state == ST_IDLE);
            PROGRAM_BUSY <= (state == ST_PROG);
        end
    end

    // =====================================================================
    // Write queue toward the memory array
    // =====================================================================
    // The queue decouples the drain from the memory's ready signal. Each
    // word holds the full word address and the byte, and stays on the
    // memory port until the memory takes it.
    write_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH),
        .AW(3)
    ) u_fifo (
        .clk(MCLK),
        .rst_n(rst_n),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(MEM_WR_VALID),
        .out_ready(MEM_WR_READY),
        .out_data({MEM_WR_ADDR, MEM_WR_DATA}),
        .empty(fifo_empty)
    );

endmodule

`default_nettype wire

// [verification/eeprom_write_slave_assertions.sv]
// Port-level checks for the two-wire memory write slave.
`timescale 1ns/1ps
`default_nettype none

module eeprom_write_slave_assertions #(
    parameter [23:0] PROG_CYCLES = 24'd200
) (
    // Clock and reset.
    input wire logic MCLK,
    input wire logic RESETN,
    // Bus and straps.
    input wire logic SCL,
    input wire logic SDA_OUT,
    input wire logic SDA_OE,
    input wire logic WRITE_INHIBIT,
    // Status.
    input wire logic STANDBY,
    input wire logic PROGRAM_BUSY,
    // Memory write port.
    input wire logic MEM_WR_VALID,
    input wire logic MEM_WR_READY,
    input wire logic [13:0] MEM_WR_ADDR,
    input wire logic [7:0] MEM_WR_DATA
);
    default clocking @(posedge MCLK);
    endclocking
    default disable iff (!RESETN);

    // Length of the current program cycle in clock cycles.
    logic [24:0] busy_cnt;
    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            busy_cnt <= 25'h0;
        end else begin
            busy_cnt <= PROGRAM_BUSY ? busy_cnt + 25'h1 : 25'h0;
        end
    end

    chk_open_drain: assert property (SDA_OE |-> !SDA_OUT)
        else $error("data line driven high");
    chk_ack_scl_low: assert property ($changed(SDA_OE) |-> !SCL)
        else $error("acknowledge moved with clock high");
    chk_ack_hold: assert property ($rose(SDA_OE) |-> SDA_OE [*6])
        else $error("acknowledge too short");
    chk_busy_quiet: assert property (PROGRAM_BUSY |-> !SDA_OE)
        else $error("bus answered while programming");
    chk_busy_standby: assert property (PROGRAM_BUSY |-> !STANDBY)
        else $error("standby while programming");
    chk_end_standby: assert property ($fell(PROGRAM_BUSY) |-> STANDBY && busy_cnt >= 25'(PROG_CYCLES))
        else $error("program cycle end wrong");
    chk_busy_bound: assert property (PROGRAM_BUSY |-> busy_cnt < 25'(PROG_CYCLES) + 25'd400)
        else $error("program cycle too long");
    chk_mem_hold: assert property (MEM_WR_VALID && !MEM_WR_READY |=> MEM_WR_VALID && $stable(MEM_WR_ADDR)
        && $stable(MEM_WR_DATA))
        else $error("memory word dropped while stalled");
    chk_write_busy: assert property (MEM_WR_VALID |-> PROGRAM_BUSY)
        else $error("memory written outside program cycle");
    chk_inhibit_block: assert property ($rose(PROGRAM_BUSY) |-> !WRITE_INHIBIT)
        else $error("program cycle under write inhibit");
endmodule

bind eeprom_write_slave eeprom_write_slave_assertions #(.PROG_CYCLES(PROG_CYCLES)) i_chk (
    .MCLK(MCLK), .RESETN(RESETN), .SCL(SCL), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
    .WRITE_INHIBIT(WRITE_INHIBIT), .STANDBY(STANDBY), .PROGRAM_BUSY(PROGRAM_BUSY),
    .MEM_WR_VALID(MEM_WR_VALID), .MEM_WR_READY(MEM_WR_READY), .MEM_WR_ADDR(MEM_WR_ADDR),
    .MEM_WR_DATA(MEM_WR_DATA)
);
`default_nettype wire

// [verification/two_wire_master.sv]
// Two-wire bus master model: drives the clock, shares the data line.
`timescale 1ns/1ps
`default_nettype none

module two_wire_master (
    input wire logic mclk,
    input wire logic sda_wire,
    output var logic scl,
    output var logic sda_drv,
    output var logic ack_stb,
    output var logic ack_val
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
        ack_stb = 1'b0;
        ack_val = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // One bit: 5 cycles low, 3 high; data moves only while low.
    task automatic clk_bit(input logic b, input logic mark);
        tick(2);
        sda_drv = b;
        tick(3);
        scl = 1'b1;
        tick(2);
        ack_val = !sda_wire;
        ack_stb = mark;
        tick(1);
        ack_stb = 1'b0;
        scl = 1'b0;
    endtask

    task automatic start();
        tick(2);
        sda_drv = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(3);
        sda_drv = 1'b0;
        tick(3);
        scl = 1'b0;
    endtask

    task automatic stop();
        tick(2);
        sda_drv = 1'b0;
        tick(3);
        scl = 1'b1;
        tick(3);
        sda_drv = 1'b1;
        tick(3);
    endtask

    // Eight bits MSB first, then the line is released for the acknowledge.
    task automatic send(input logic [7:0] d);
        for (int i = 7; i >= 0; i--) clk_bit(d[i], 1'b0);
        clk_bit(1'b1, 1'b1);
    endtask

    task automatic clocks(input int n);
        repeat (n) clk_bit(1'b1, 1'b0);
    endtask
endmodule
`default_nettype wire

// [verification/eeprom_write_slave_tb.sv]
// Self-checking testbench for the two-wire memory write slave.
`timescale 1ns/1ps
`default_nettype none

module eeprom_write_slave_tb;
    logic mclk, resetn, inhibit, ready, stall, scl, sda_drv, sda, ack_stb, ack_val;
    logic oe, sdo, stb, busy, valid;
    logic [2:0] cs;
    logic [13:0] addr;
    logic [7:0] data;
    logic [7:0] page [64];
    logic [63:0] hit;
    logic ackq [$];
    logic [21:0] memq [$];
    int err_count, checked;

    eeprom_write_slave #(.PROG_CYCLES(24'd200), .FIFO_DEPTH(8)) i_dut (
        .MCLK(mclk), .RESETN(resetn), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sdo), .SDA_OE(oe),
        .CHIP_SELECT_ADDRESS_PINS(cs), .WRITE_INHIBIT(inhibit), .STANDBY(stb), .PROGRAM_BUSY(busy),
        .MEM_WR_VALID(valid), .MEM_WR_READY(ready), .MEM_WR_ADDR(addr), .MEM_WR_DATA(data)
    );
    two_wire_master i_master (
        .mclk(mclk), .sda_wire(sda), .scl(scl), .sda_drv(sda_drv), .ack_stb(ack_stb), .ack_val(ack_val)
    );

    // Open-drain line with pull-up.
    assign sda = sda_drv & (oe ? sdo : 1'b1);

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    always @(negedge mclk) ready <= !stall && ($urandom % 4 != 0);

    task automatic chk(input logic [21:0] g, input logic [21:0] e);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic test_done();
        $display("Checks %0d, errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge mclk) begin
        if (ack_stb === 1'b1)
            chk(22'(ack_val), ackq.size() ? 22'(ackq.pop_front()) : {22{1'bx}});
        if (valid === 1'b1 && ready === 1'b1)
            chk({addr, data}, memq.size() ? memq.pop_front() : {22{1'bx}});
    end

    task automatic byte_out(input logic [7:0] d, input logic a);
        ackq.push_back(a);
        i_master.send(d);
    endtask

    task automatic dev(input logic [3:0] t, input logic [2:0] c, input logic rw, input logic a);
        i_master.start();
        byte_out({t, c, rw}, a);
    endtask

    task automatic waitbusy(input logic v);
        int i;
        for (i = 0; i < 1000 && busy !== v; i++) @(negedge mclk);
        if (i == 1000) begin
            err_count++;
            test_done();
        end
    endtask

    task automatic write(input logic [7:0] hi, input logic [7:0] lo, input int n);
        logic [7:0] d;
        logic [5:0] off;
        hit = 64'h0;
        off = lo[5:0];
        dev(4'hA, cs, 1'b0, 1'b1);
        byte_out(hi, 1'b1);
        byte_out(lo, 1'b1);
        repeat (n) begin
            d = 8'($urandom);
            byte_out(d, 1'b1);
            page[off] = d;
            hit[off] = 1'b1;
            off++;
        end
        for (int k = 0; k < 64; k++)
            if (hit[k] && !inhibit) memq.push_back({hi[5:0], lo[7:6], 6'(k), page[k]});
        i_master.stop();
    endtask

    initial begin
        int s;
        resetn = 1'b0;
        inhibit = 1'b0;
        stall = 1'b0;
        ready = 1'b0;
        cs = 3'h5;
        s = $urandom(17926);
        repeat (12) @(negedge mclk);
        resetn = 1'b1;
        repeat (4) @(negedge mclk);
        chk(22'({stb, busy, oe, valid}), 22'h8);
        cs = 3'($urandom);
        write(8'hC0 | 8'($urandom), 8'($urandom), 1);
        waitbusy(1'b1);
        dev(4'hA, cs, 1'b0, 1'b0);
        waitbusy(1'b0);
        chk(22'(stb), 22'h1);
        dev(4'hA, cs, 1'b1, 1'b1);
        i_master.stop();
        stall = 1'b1;
        write(8'($urandom), 8'h3E, 66);
        waitbusy(1'b1);
        repeat (40) @(negedge mclk);
        stall = 1'b0;
        waitbusy(1'b0);
        inhibit = 1'b1;
        write(8'h01, 8'h10, 2);
        for (int k = 0; k < 20; k++) begin
            @(negedge mclk);
            chk(22'(busy), 22'h0);
        end
        inhibit = 1'b0;
        dev(4'h5, cs, 1'b0, 1'b0);
        byte_out(8'h00, 1'b0);
        dev(4'hA, cs ^ 3'h1, 1'b0, 1'b0);
        byte_out(8'h00, 1'b0);
        i_master.stop();
        i_master.start();
        i_master.clocks(4);
        i_master.start();
        i_master.clocks(9);
        i_master.start();
        i_master.stop();
        write(8'h3F, 8'hFF, 1);
        waitbusy(1'b1);
        waitbusy(1'b0);
        chk(22'(ackq.size() + memq.size()), 22'h0);
        test_done();
    end
endmodule
`default_nettype wire
